// ===== bench/pio_peer.sv
`timescale 1ns/10ps
module pio_peer
(
   input wire logic i_clk,
   input wire logic i_stb_go,
   input wire logic i_ack_go,
   input wire logic [7:0] i_byte,
   input wire logic [7:0] i_pa_out,
   input wire logic [7:0] i_pa_oe_n,
   input wire logic [7:0] i_pc_out,
   input wire logic [7:0] i_pc_oe_n,
   output logic [7:0] o_pa_pin,
   output logic [7:0] o_pc_pin
);
   logic [1:0] stb_cnt = 2'h0;
   logic [1:0] ack_cnt = 2'h0;
   // Strobes low two cycles; data held one cycle past the rising strobe
   wire logic stb_n = stb_cnt < 2'h2;
   wire logic ack_n = ack_cnt < 2'h2;
   // Released data shows the inverse so a late capture cannot pass
   wire logic [7:0] pa_drv = (stb_cnt != 2'h0) ? i_byte : ~i_byte;
   // Idle third-port lines have pull-ups; one strobe serves both strobed ports
   wire logic [7:0] pc_drv = {1'b1, ack_n, 1'b1, stb_n, 1'b1, stb_n, 2'h3};
   assign o_pa_pin = (i_pa_out & ~i_pa_oe_n) | (pa_drv & i_pa_oe_n);
   assign o_pc_pin = (i_pc_out & ~i_pc_oe_n) | (pc_drv & i_pc_oe_n);
   always @(posedge i_clk) begin
      stb_cnt <= i_stb_go ? 2'h3 : stb_cnt - {1'b0, stb_cnt != 2'h0};
      ack_cnt <= i_ack_go ? 2'h3 : ack_cnt - {1'b0, ack_cnt != 2'h0};
   end
endmodule

// ===== bench/pio_port_properties.sv
`timescale 1ns/10ps
// ********
// Port checks
// ********
module pio_port_props
   import pio_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire pio_cfg_t i_cfg,
   input wire pio_req_t i_req,
   input wire pio_rsp_t o_rsp,
   input wire logic [7:0] o_pa_oe_n,
   input wire logic [7:0] o_pb_oe_n,
   input wire logic [7:0] o_pc_out,
   input wire logic [7:0] o_pc_oe_n,
   input wire logic o_irq_a
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   reset_idle_a: assert property ($fell(i_srst) |-> (o_pa_oe_n & o_pb_oe_n & o_pc_oe_n) == 8'hff)
      else $error("pins driven after reset");
   rd_answer_a: assert property (i_ce && i_req.rd |=> o_rsp.valid)
      else $error("read not answered");
   no_answer_a: assert property (i_ce && !i_req.rd |=> !o_rsp.valid)
      else $error("stray answer");
   a_in_float_a: assert property (i_ce && i_cfg.mode_a == PIO_A_LAT_IN |=> o_pa_oe_n == 8'hff && !o_irq_a)
      else $error("port a driven in input mode");
   a_out_drive_a: assert property (i_ce && i_cfg.mode_a == PIO_A_LAT_OUT |=> o_pa_oe_n == 8'h00)
      else $error("port a not driven");
   b_in_float_a: assert property (i_ce && i_cfg.mode_b == PIO_B_LAT_IN |=> o_pb_oe_n == 8'hff)
      else $error("port b driven in input mode");
   b_claim_a: assert property (i_ce && i_cfg.mode_b[0] |=> o_pc_oe_n[2:0] == 3'b100)
      else $error("port b handshake lines wrong");
   bidir_claim_a: assert property (i_ce && i_cfg.mode_a == PIO_A_BIDIR |=> o_pc_oe_n[7:3] == 5'b01010)
      else $error("bidirectional handshake lines wrong");
   obf_write_a: assert property (i_ce && i_req.wr && i_req.sel == PIO_SEL_A
      && i_cfg.mode_a == PIO_A_STB_OUT |=> !o_pc_out[7])
      else $error("output full flag not raised");
endmodule
bind pio_port pio_port_props u_props (.i_clk, .i_srst, .i_ce, .i_cfg, .i_req, .o_rsp, .o_pa_oe_n, .o_pb_oe_n,
   .o_pc_out, .o_pc_oe_n, .o_irq_a);

// ===== bench/testbench.sv
`timescale 1ns/10ps
module testbench
   import pio_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   pio_cfg_t cfg = '0;
   pio_req_t req = '0;
   pio_rsp_t rsp;
   logic stb_go = 1'b0;
   logic ack_go = 1'b0;
   logic ce = 1'b1;
   logic [7:0] pb_pin = 8'h3c;
   logic [7:0] pa_out, pa_oe_n, pb_out, pb_oe_n, pc_out, pc_oe_n, pa_pin, pc_pin;
   logic irq_a, irq_b;
   int fails = 0;
   int cmp_count = 0;
   always #10 i_clk = ~i_clk;
   pio_port DUT (.i_clk, .i_srst, .i_ce(ce), .i_cfg(cfg), .i_req(req), .o_rsp(rsp), .i_pa_in(pa_pin),
      .o_pa_out(pa_out), .o_pa_oe_n(pa_oe_n), .i_pb_in(pb_pin), .o_pb_out(pb_out), .o_pb_oe_n(pb_oe_n),
      .i_pc_in(pc_pin), .o_pc_out(pc_out), .o_pc_oe_n(pc_oe_n), .o_irq_a(irq_a), .o_irq_b(irq_b));
   pio_peer u_peer (.i_clk, .i_stb_go(stb_go), .i_ack_go(ack_go), .i_byte(8'h5a), .i_pa_out(pa_out),
      .i_pa_oe_n(pa_oe_n), .i_pc_out(pc_out), .i_pc_oe_n(pc_oe_n), .o_pa_pin(pa_pin), .o_pc_pin(pc_pin));
   // ********
   // Shared tasks
   // ********
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] got);
      cmp_count++;
      if (got !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic setc(input pio_mode_a_t a, input pio_mode_b_t b, input logic [4:0] f);
      @(negedge i_clk);
      cfg = {a, b, f};
      repeat (2) @(negedge i_clk);
   endtask
   task automatic access(input logic w, input pio_sel_t s, input logic [7:0] d);
      @(negedge i_clk);
      req = '{wr: w, rd: !w, sel: s, data: d};
      @(negedge i_clk);
      req = '0;
   endtask
   task automatic rd(input pio_sel_t s, input logic [7:0] e, input string nm);
      access(1'b0, s, 8'h00);
      chk(nm, e, rsp.valid === 1'b1 ? rsp.data : 8'hxx);
   endtask
   task automatic pulse(input logic ack);
      @(negedge i_clk);
      ack_go = ack;
      stb_go = !ack;
      @(negedge i_clk);
      ack_go = 1'b0;
      stb_go = 1'b0;
      for (int n = 0; n < 20 && (irq_a | irq_b) !== 1'b1; n++) @(negedge i_clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_latched;
      setc(PIO_A_LAT_OUT, PIO_B_LAT_IN, 5'b10000);
      access(1'b1, PIO_SEL_A, 8'ha5);
      chk("a drive", 8'ha5, pa_out & ~pa_oe_n);
      ce = 1'b0;
      access(1'b1, PIO_SEL_A, 8'h11);
      ce = 1'b1;
      chk("a frozen", 8'ha5, pa_out);
      rd(PIO_SEL_B, 8'h3c, "b read");
      chk("c enables", 8'h0f, pc_oe_n);
      access(1'b1, PIO_SEL_C, 8'h96);
      rd(PIO_SEL_C, 8'h9f, "c read");
      rd(pio_sel_t'(2'h3), 8'h00, "no port");
      $display("latched test done");
   endtask
   task automatic t_strobe_in;
      setc(PIO_A_STB_IN, PIO_B_STB_OUT, 5'b00100);
      chk("claims", 8'hd4, pc_oe_n);
      pulse(1'b0);
      chk("in full", 8'h07, {5'h0, pc_out[5], pc_out[3], irq_a});
      rd(PIO_SEL_A, 8'h5a, "strobed in");
      chk("in cleared", 8'h00, {5'h0, pc_out[5], pc_out[3], irq_a});
      $display("strobed input test done");
   endtask
   task automatic t_strobe_out;
      setc(PIO_A_STB_OUT, PIO_B_LAT_IN, 5'b00010);
      access(1'b1, PIO_SEL_A, 8'hc3);
      chk("out data", 8'hc3, pa_out & ~pa_oe_n);
      chk("out full", 8'h00, {7'h0, pc_out[7]});
      pulse(1'b1);
      chk("out empty", 8'h07, {5'h0, pc_out[7], pc_out[3], irq_a});
      $display("strobed output test done");
   endtask
   task automatic t_bidir;
      setc(PIO_A_BIDIR, PIO_B_LAT_IN, 5'b01000);
      access(1'b1, PIO_SEL_C, 8'hff);
      chk("bidir float", 8'hff, pa_oe_n);
      chk("bidir claims", 8'h50, pc_oe_n);
      chk("claimed kept", 8'h27, {2'h0, pc_out[7], pc_out[5], pc_out[3], pc_out[2:0]});
      access(1'b1, PIO_SEL_A, 8'h3c);
      @(negedge i_clk);
      ack_go = 1'b1;
      @(negedge i_clk);
      ack_go = 1'b0;
      @(negedge i_clk);
      chk("bidir drive", 8'h3c, pa_out & ~pa_oe_n);
      setc(PIO_A_LAT_IN, PIO_B_LAT_IN, 5'b11000);
      chk("claimed left", 8'h97, pc_out);
      $display("bidirectional test done");
   endtask
   task automatic t_port_b;
      setc(PIO_A_LAT_IN, PIO_B_STB_IN, 5'b00001);
      pb_pin = 8'h81;
      pulse(1'b0);
      pb_pin = 8'h00;
      chk("b in full", 8'h07, {5'h0, pc_out[1], pc_out[0], irq_b});
      rd(PIO_SEL_B, 8'h81, "b strobed in");
      setc(PIO_A_LAT_IN, PIO_B_STB_OUT, 5'b00001);
      access(1'b1, PIO_SEL_B, 8'h69);
      chk("b out data", 8'h69, pb_out & ~pb_oe_n);
      chk("b out full", 8'h00, {6'h0, pc_out[1], pc_out[0]});
      pulse(1'b0);
      chk("b out empty", 8'h07, {5'h0, pc_out[1], pc_out[0], irq_b});
      $display("port b test done");
   endtask
   initial begin
      repeat (10) @(negedge i_clk);
      i_srst = 1'b0;
      chk("reset enables", 8'hff, pa_oe_n & pb_oe_n & pc_oe_n);
      t_latched;
      t_strobe_in;
      t_strobe_out;
      t_bidir;
      t_port_b;
      tally_and_finish;
   end
   initial begin
      #20000;
      fails++;
      tally_and_finish;
   end
endmodule

// ===== logic/pio_port.sv
`timescale 1ns/10ps
`include "pio_defs.svh"

// Notes on behaviour
// - Two 8-line ports, third split in halves
// - Any mix of input, output, bidirectional
// - Mode limits: A five, B four, C two
// - Strobed modes take third-port handshake lines
// - Bidirectional only on A, takes handshake lines
// - Strobed modes flag input full, output full
module pio_port
   import pio_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire pio_cfg_t i_cfg,
   input wire pio_req_t i_req,
   output pio_rsp_t o_rsp,
   input wire logic [7:0] i_pa_in,
   output logic [7:0] o_pa_out,
   output logic [7:0] o_pa_oe_n,
   input wire logic [7:0] i_pb_in,
   output logic [7:0] o_pb_out,
   output logic [7:0] o_pb_oe_n,
   input wire logic [7:0] i_pc_in,
   output logic [7:0] o_pc_out,
   output logic [7:0] o_pc_oe_n,
   output logic o_irq_a,
   output logic o_irq_b
);

   // ****************************************
   // State
   // ****************************************
   logic [7:0] out_a, out_b, pc_latch, in_a, in_b;
   logic ibf_a, obf_a, intr_in_a, intr_out_a;
   logic ibf_b, obf_b, intr_b;
   logic stb_a_q, ack_a_q, stb_b_q;

   // ****************************************
   // Mode decode
   // ****************************************
   wire a_sin = i_cfg.mode_a == PIO_A_STB_IN;
   wire a_sout = i_cfg.mode_a == PIO_A_STB_OUT;
   wire a_bi = i_cfg.mode_a == PIO_A_BIDIR;
   wire a_lout = i_cfg.mode_a == PIO_A_LAT_OUT;
   wire a_in_hs = a_sin | a_bi;
   wire a_out_hs = a_sout | a_bi;
   wire a_hs = a_in_hs | a_out_hs;
   wire b_sin = i_cfg.mode_b == PIO_B_STB_IN;
   wire b_sout = i_cfg.mode_b == PIO_B_STB_OUT;
   wire b_hs = b_sin | b_sout;
   wire b_out = b_sout | (i_cfg.mode_b == PIO_B_LAT_OUT);

   // ****************************************
   // Handshake edges from the third port
   // ****************************************
   wire stb_a = i_pc_in[`PIO_C_STB_A];
   wire ack_a = i_pc_in[`PIO_C_ACK_A];
   wire stb_b = i_pc_in[`PIO_C_STB_B];
   wire stb_a_fall = stb_a_q & ~stb_a;
   wire stb_a_rise = ~stb_a_q & stb_a;
   wire ack_a_fall = ack_a_q & ~ack_a;
   wire ack_a_rise = ~ack_a_q & ack_a;
   wire stb_b_fall = stb_b_q & ~stb_b;
   wire stb_b_rise = ~stb_b_q & stb_b;

   // ****************************************
   // Processor requests
   // ****************************************
   wire wr_a = i_req.wr & (i_req.sel == PIO_SEL_A);
   wire wr_b = i_req.wr & (i_req.sel == PIO_SEL_B);
   wire wr_c = i_req.wr & (i_req.sel == PIO_SEL_C);
   wire rd_a = i_req.rd & (i_req.sel == PIO_SEL_A);
   wire rd_b = i_req.rd & (i_req.sel == PIO_SEL_B);

   // ****************************************
   // Buffer flags; a set in the same cycle as a clear wins
   // ****************************************
   wire next_ibf_a = a_in_hs & (stb_a_fall | (ibf_a & ~rd_a));
   wire next_intr_in_a = a_in_hs & i_cfg.inte_a_in &
      ((stb_a_rise & ibf_a) | (intr_in_a & ~rd_a));
   wire next_obf_a = a_out_hs & (wr_a | (obf_a & ~ack_a_fall));
   wire next_intr_out_a = a_out_hs & i_cfg.inte_a_out &
      ((ack_a_rise & ~obf_a) | (intr_out_a & ~wr_a));
   wire next_irq_a = next_intr_in_a | next_intr_out_a;

   // Port B shares one strobe/acknowledge line between its two strobed modes
   wire next_ibf_b = b_sin & (stb_b_fall | (ibf_b & ~rd_b));
   wire next_obf_b = b_sout & (wr_b | (obf_b & ~stb_b_fall));
   wire next_intr_b = b_hs & i_cfg.inte_b &
      ((b_sin & stb_b_rise & ibf_b) | (b_sout & stb_b_rise & ~obf_b) |
       (intr_b & ~(b_sin ? rd_b : wr_b)));

   // ****************************************
   // Input latches
   // ****************************************
   wire load_a = a_in_hs ? ~stb_a : 1'b1;
   wire load_b = b_sin ? ~stb_b : 1'b1;
   wire [7:0] next_in_a = load_a ? i_pa_in : in_a;
   wire [7:0] next_in_b = load_b ? i_pb_in : in_b;

   // ****************************************
   // Third-port handshake overlay
   // ****************************************
   wire [7:0] claim = (b_hs ? `PIO_CLAIM_B : 8'h00) |
      (a_hs ? `PIO_CLAIM_A_ANY : 8'h00) |
      (a_in_hs ? `PIO_CLAIM_A_IN : 8'h00) |
      (a_out_hs ? `PIO_CLAIM_A_OUT : 8'h00);
   wire [7:0] hs_val;
   assign hs_val[`PIO_C_INTR_B] = next_intr_b;
   assign hs_val[`PIO_C_FLAG_B] = b_sin ? next_ibf_b : ~next_obf_b;
   assign hs_val[`PIO_C_STB_B] = 1'b1;
   assign hs_val[`PIO_C_INTR_A] = next_irq_a;
   assign hs_val[`PIO_C_STB_A] = 1'b1;
   assign hs_val[`PIO_C_IBF_A] = next_ibf_a;
   assign hs_val[`PIO_C_ACK_A] = 1'b1;
   assign hs_val[`PIO_C_OBF_A] = ~next_obf_a;
   wire [7:0] hs_oe_n = `PIO_HS_INPUTS;

   // Writes only reach third-port bits that no handshake holds
   wire [7:0] next_pc_latch = wr_c ? ((i_req.data & ~claim) | (pc_latch & claim)) : pc_latch;
   wire [7:0] next_pc_out;
   wire [7:0] next_pc_oe_n;
   wire [7:0] pc_view;

   genvar gi;
   generate
      for (gi = 0; gi < `PIO_PORT_W; gi = gi + 1) begin : g_pc
         wire half_out = (gi < `PIO_HALF_W) ? i_cfg.pc_lo_out : i_cfg.pc_hi_out;
         assign next_pc_out[gi] = claim[gi] ? hs_val[gi] : next_pc_latch[gi];
         assign next_pc_oe_n[gi] = claim[gi] ? hs_oe_n[gi] : ~half_out;
         assign pc_view[gi] = o_pc_oe_n[gi] ? i_pc_in[gi] : o_pc_out[gi];
      end
   endgenerate

   // ****************************************
   // Data port drive and read-back
   // ****************************************
   wire [7:0] next_out_a = wr_a ? i_req.data : out_a;
   wire [7:0] next_out_b = wr_b ? i_req.data : out_b;
   // Bidirectional port drives only while the peripheral acknowledges
   wire a_drive = a_lout | a_sout | (a_bi & ~ack_a);
   wire [7:0] next_pa_oe_n = a_drive ? 8'h00 : 8'hff;
   wire [7:0] next_pb_oe_n = b_out ? 8'h00 : 8'hff;
   wire [7:0] rd_val = (i_req.sel == PIO_SEL_A) ? ((a_lout | a_sout) ? out_a : in_a) :
      (i_req.sel == PIO_SEL_B) ? (b_out ? out_b : in_b) :
      (i_req.sel == PIO_SEL_C) ? pc_view : 8'h00;

   // ****************************************
   // Registers
   // ****************************************
   // Port data latches
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         out_a <= `PIO_RST_DATA;
         out_b <= `PIO_RST_DATA;
         pc_latch <= `PIO_RST_DATA;
         in_a <= `PIO_RST_DATA;
         in_b <= `PIO_RST_DATA;
      end else if (i_ce) begin
         out_a <= next_out_a;
         out_b <= next_out_b;
         pc_latch <= next_pc_latch;
         in_a <= next_in_a;
         in_b <= next_in_b;
      end
   end

   // Buffer and interrupt flags
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         {ibf_a, obf_a, intr_in_a, intr_out_a} <= 4'h0;
         {ibf_b, obf_b, intr_b} <= 3'h0;
      end else if (i_ce) begin
         {ibf_a, obf_a, intr_in_a, intr_out_a} <= {next_ibf_a, next_obf_a, next_intr_in_a, next_intr_out_a};
         {ibf_b, obf_b, intr_b} <= {next_ibf_b, next_obf_b, next_intr_b};
      end
   end

   // History starts at the idle high level so leaving reset makes no false edge
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         {stb_a_q, ack_a_q, stb_b_q} <= {3{`PIO_RST_STROBE}};
      end else if (i_ce) begin
         {stb_a_q, ack_a_q, stb_b_q} <= {stb_a, ack_a, stb_b};
      end
   end

   // Pin drive
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_pa_out <= `PIO_RST_DATA;
         o_pa_oe_n <= `PIO_RST_OE_N;
         o_pb_out <= `PIO_RST_DATA;
         o_pb_oe_n <= `PIO_RST_OE_N;
         o_pc_out <= `PIO_RST_DATA;
         o_pc_oe_n <= `PIO_RST_OE_N;
      end else if (i_ce) begin
         o_pa_out <= next_out_a;
         o_pa_oe_n <= next_pa_oe_n;
         o_pb_out <= next_out_b;
         o_pb_oe_n <= next_pb_oe_n;
         o_pc_out <= next_pc_out;
         o_pc_oe_n <= next_pc_oe_n;
      end
   end

   // Interrupt requests and read answer
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_irq_a <= 1'b0;
         o_irq_b <= 1'b0;
         o_rsp <= '0;
      end else if (i_ce) begin
         o_irq_a <= next_irq_a;
         o_irq_b <= next_intr_b;
         o_rsp.valid <= i_req.rd;
         o_rsp.data <= i_req.rd ? rd_val : 8'h00;
      end
   end

endmodule

// ===== pkg/pio_defs.svh
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// ****************************************
// Port widths
// ****************************************
`define PIO_PORT_W 8
`define PIO_HALF_W 4

// ****************************************
// Handshake line positions on the third port
// ****************************************
`define PIO_C_INTR_B 0
`define PIO_C_FLAG_B 1
`define PIO_C_STB_B 2
`define PIO_C_INTR_A 3
`define PIO_C_STB_A 4
`define PIO_C_IBF_A 5
`define PIO_C_ACK_A 6
`define PIO_C_OBF_A 7

// Bits taken by each group of handshake lines
`define PIO_CLAIM_B 8'h07
`define PIO_CLAIM_A_ANY 8'h08
`define PIO_CLAIM_A_IN 8'h30
`define PIO_CLAIM_A_OUT 8'hc0
// Handshake bits that are inputs from the peripheral
`define PIO_HS_INPUTS 8'h54

// ****************************************
// Reset values
// ****************************************
`define PIO_RST_DATA 8'h00
`define PIO_RST_OE_N 8'hff
`define PIO_RST_STROBE 1'b1

`endif

// ===== pkg/pio_pkg.sv
package pio_pkg;

   // Gray codes along latched in -> strobed in -> strobed out -> latched out
   typedef enum logic [2:0] {
      PIO_A_LAT_IN = 3'h0,
      PIO_A_STB_IN = 3'h1,
      PIO_A_STB_OUT = 3'h3,
      PIO_A_LAT_OUT = 3'h2,
      PIO_A_BIDIR = 3'h6
   } pio_mode_a_t;

   typedef enum logic [1:0] {
      PIO_B_LAT_IN = 2'h0,
      PIO_B_STB_IN = 2'h1,
      PIO_B_STB_OUT = 2'h3,
      PIO_B_LAT_OUT = 2'h2
   } pio_mode_b_t;

   typedef enum logic [1:0] {
      PIO_SEL_A = 2'h0,
      PIO_SEL_B = 2'h1,
      PIO_SEL_C = 2'h2
   } pio_sel_t;

   typedef struct packed {
      pio_mode_a_t mode_a;
      pio_mode_b_t mode_b;
      logic pc_hi_out;
      logic pc_lo_out;
      logic inte_a_in;
      logic inte_a_out;
      logic inte_b;
   } pio_cfg_t;

   typedef struct packed {
      logic wr;
      logic rd;
      pio_sel_t sel;
      logic [7:0] data;
   } pio_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } pio_rsp_t;

endpackage
